// File: core/fll_clock_mode_controller.sv
// mode sequencer, filter register and lock tracking of the clock generator
// assumes count_error/sample_valid come from the pulse counter on ref_clk; pins are asynchronous
`timescale 1ns/1ps
module fll_clock_mode_controller
  import fll_clock_pkg::*;
#(
  parameter int unsigned DIV_W = 3,
  parameter int unsigned MFD_W = 3
) (
  input  wire logic                     ref_clk,
  input  wire logic                     rst,
  input  wire logic                     por,
  input  wire logic [ADDR_W-1:0]        reg_addr,
  input  wire logic [DATA_W-1:0]        reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [DATA_W-1:0]        reg_rdata,
  input  wire logic                     stop_req,
  input  wire logic                     debug_enable,
  input  wire logic signed [FLT_W-1:0]  count_error,
  input  wire logic                     sample_valid,
  input  wire logic                     osc_static,
  input  wire logic                     osc_loss,
  input  wire logic                     ref_loss,
  input  wire logic                     ext_ref_ok_pin,
  input  wire logic                     crystal_input_pin,
  input  wire logic [DIV_W-1:0]         out_divider,
  input  wire logic [MFD_W-1:0]         multiplier_setting,
  output logic      [FLT_W-1:0]         filter_value,
  output logic                          filter_update,
  output logic      [7:0]               internal_ref_trim,
  output logic      [1:0]               actual_mode,
  output logic                          locked,
  output logic                          osc_enable,
  output logic                          int_ref_enable,
  output logic                          ext_ref_enable,
  output logic                          crystal_select,
  output logic                          crystal_range,
  output logic                          ext_source_select,
  output logic                          extra_div2,
  output logic      [DIV_W-1:0]         out_divide,
  output logic      [MFD_W-1:0]         loop_multiplier,
  output logic                          clock_feed_en
);

  typedef struct packed {
    mode_t              state;
    logic [FLT_W-1:0]   filter;
    logic [7:0]         low_stage;
    logic [2:0]         latch_cnt;
    logic [1:0]         req;
    logic               ref_sel;
    logic               range_sel;
    logic               osc_stop_en;
    logic               lock;
    logic [3:0]         lock_cnt;
    logic               first_lock;
    logic signed [13:0] acc;
    logic [1:0]         acc_cnt;
    logic [FLT_W-1:0]   prev_err;
    logic [1:0]         stable_cnt;
    logic               osc_stable;
    logic               loss_flag;
    logic               off_fbe;
    logic               scm_wait;
    logic               fbe_hold;
    logic [12:0]        xtal_cnt;
    logic               xtal_ready;
    logic               s1_ext_ref_valid_flag;
    logic               s2_ext_ref_valid_flag;
    logic               s1_xtal;
    logic               s2_xtal;
    logic               s3_xtal;
    logic [DATA_W-1:0]  rdata;
    logic               filt_upd;
  } state_t;

  state_t     s_q;
  state_t     s_d;
  logic [7:0] trim_q;
  logic [7:0] trim_d;

  function automatic logic [11:0] abs12(input logic signed [12:0] v);
    logic [12:0] m;
    m = v[12] ? 13'(-v) : 13'(v);
    abs12 = m[12] ? 12'hfff : m[11:0];
  endfunction

  // the loop pulls the filter against the error; clamp keeps the oscillator code in range
  function automatic logic [FLT_W-1:0] flt_sub(input logic [FLT_W-1:0] f, input logic signed [13:0] e);
    logic signed [14:0] t;
    t = $signed({3'b000, f}) - 15'(e);
    if (t < 0)
      flt_sub = '0;
    else if (t > 15'sd4095)
      flt_sub = 12'hfff;
    else
      flt_sub = t[FLT_W-1:0];
  endfunction

  function automatic mode_t target_mode(input logic [1:0] req, input logic ext_ref_valid_flag, input logic osc_stable_flag);
    case (req)
      REQ_FEI: target_mode = ST_FEI;
      REQ_FBE: target_mode = ext_ref_valid_flag ? ST_FBE : ST_SCM;
      REQ_FEE: target_mode = (ext_ref_valid_flag && osc_stable_flag) ? ST_FEE : ST_SCM;
      default: target_mode = ST_SCM;
    endcase
  endfunction

  logic ext_ref_valid_flag_ok;
  logic xtal_edge;
  logic run_mode;
  logic signed [12:0] err_step;

  assign xtal_edge = s_q.s2_xtal & ~s_q.s3_xtal;
  assign ext_ref_valid_flag_ok   = s_q.s2_ext_ref_valid_flag & (~s_q.ref_sel | s_q.xtal_ready);  // see RULE_11
  assign run_mode  = (s_q.state == ST_FEI) || (s_q.state == ST_FEE);
  assign err_step  = 13'(count_error) - 13'($signed(s_q.prev_err));

  always_comb begin
    s_d          = s_q;
    trim_d       = trim_q;
    s_d.s1_ext_ref_valid_flag  = ext_ref_ok_pin;
    s_d.s2_ext_ref_valid_flag  = s_q.s1_ext_ref_valid_flag;
    s_d.s1_xtal  = crystal_input_pin;
    s_d.s2_xtal  = s_q.s1_xtal;
    s_d.s3_xtal  = s_q.s2_xtal;
    s_d.filt_upd = 1'b0;
    s_d.rdata    = '0;
    if (s_q.latch_cnt != 3'h0) begin
      s_d.latch_cnt = s_q.latch_cnt - 3'h1;
    end

    // crystal start-up count; a direct clock needs no warm-up
    if (!s_q.ref_sel) begin
      s_d.xtal_cnt   = '0;
      s_d.xtal_ready = 1'b0;
    end else if (xtal_edge && !s_q.xtal_ready) begin
      s_d.xtal_cnt = s_q.xtal_cnt + 13'h1;
      if (s_q.xtal_cnt == XTAL_START_CYCLES - 13'h1) begin
        s_d.xtal_ready = 1'b1;  // see RULE_11
      end
    end

    if (reg_rd) begin
      case (reg_addr)
        IDX_FILTER_UPPER: s_d.rdata = {4'h0, s_q.filter[11:8]};  // see RULE_02
        IDX_FILTER_LOWER: s_d.rdata = s_q.filter[7:0];  // see RULE_02
        IDX_TRIM:         s_d.rdata = trim_q;
        IDX_CONTROL:      s_d.rdata = {3'h0, s_q.osc_stop_en, s_q.range_sel, s_q.ref_sel, s_q.req};
        IDX_STATUS:       s_d.rdata = {2'h0, s_q.loss_flag, ext_ref_valid_flag_ok, s_q.osc_stable, s_q.lock, actual_mode};
        default:          s_d.rdata = '0;
      endcase
    end

    if (reg_wr) begin
      case (reg_addr)
        IDX_FILTER_LOWER: s_d.low_stage = reg_wdata;
        IDX_FILTER_UPPER: begin
          // the new code needs time to reach the oscillator; a second write would tear it
          if (s_q.req == REQ_SCM && s_q.latch_cnt == 3'h0) begin  // see RULE_01 see RULE_03
            s_d.filter    = {reg_wdata[3:0], s_q.low_stage};  // see RULE_02 see RULE_13
            s_d.latch_cnt = LATCH_CYCLES;
            s_d.filt_upd  = 1'b1;
          end
        end
        IDX_TRIM:    trim_d = reg_wdata;  // see RULE_04
        IDX_CONTROL: begin
          s_d.req         = reg_wdata[CTL_REQ_LSB +: 2];
          s_d.ref_sel     = reg_wdata[CTL_REFSEL];
          s_d.range_sel   = reg_wdata[CTL_RANGE];
          s_d.osc_stop_en = reg_wdata[CTL_OSCSTOP];
        end
        IDX_STATUS: begin
          if (reg_wdata[STS_LOSS]) begin
            s_d.loss_flag = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // oscillator stability monitor
    if (s_q.state != ST_OFF && sample_valid) begin
      s_d.prev_err = count_error;
      if (abs12(err_step) <= UNLOCK_WIN && !osc_static) begin
        if (s_q.stable_cnt != 2'h2) begin
          s_d.stable_cnt = s_q.stable_cnt + 2'h1;
        end
        if (s_q.stable_cnt >= 2'h1) begin
          s_d.osc_stable = 1'b1;  // see RULE_24
        end
      end else begin
        s_d.stable_cnt = 2'h0;
      end
    end

    // closed loop: lock detector and filter update
    if (run_mode && sample_valid) begin
      if (!s_q.lock) begin
        s_d.filter   = flt_sub(s_q.filter, 14'(count_error));  // see RULE_17
        s_d.filt_upd = 1'b1;
        if (abs12(13'(count_error)) <= LOCK_WIN) begin
          s_d.lock_cnt = s_q.lock_cnt + 4'h1;
          if (s_q.lock_cnt == LOCK_SAMPLES - 4'h1) begin
            s_d.lock       = 1'b1;  // see RULE_18
            s_d.first_lock = 1'b1;
            s_d.acc        = '0;
            s_d.acc_cnt    = 2'h0;
          end
        end else begin
          s_d.lock_cnt = 4'h0;  // see RULE_17
        end
      end else if (abs12(13'(count_error)) > UNLOCK_WIN) begin
        s_d.lock     = 1'b0;  // see RULE_17
        s_d.lock_cnt = 4'h0;
      end else begin
        // averaging four errors trades tracking speed for less jitter once locked
        s_d.acc_cnt = s_q.acc_cnt + 2'h1;
        if (s_q.acc_cnt == 2'h3) begin
          s_d.filter   = flt_sub(s_q.filter, (s_q.acc + 14'(count_error)) >>> 2);  // see RULE_18
          s_d.filt_upd = 1'b1;
          s_d.acc      = '0;
        end else begin
          s_d.acc = s_q.acc + 14'(count_error);
        end
      end
    end

    if (s_q.fbe_hold && ext_ref_valid_flag_ok) begin
      s_d.fbe_hold = 1'b0;  // see RULE_09
    end

    case (s_q.state)
      ST_OFF: begin
        if (!stop_req) begin
          if (s_q.off_fbe) begin
            s_d.state    = ST_FBE;  // see RULE_19
            s_d.fbe_hold = ~ext_ref_valid_flag_ok;  // see RULE_09
          end else begin
            s_d.state    = ST_SCM;  // see RULE_12
            s_d.scm_wait = s_q.req[0];  // see RULE_15
          end
        end
      end
      default: begin
        if (stop_req && !debug_enable && !s_q.osc_stop_en) begin  // see RULE_07
          s_d.state      = ST_OFF;  // see RULE_06
          s_d.off_fbe    = (s_q.req == REQ_FBE) && ext_ref_valid_flag_ok;
          s_d.osc_stable = 1'b0;  // see RULE_24
          s_d.stable_cnt = 2'h0;
          s_d.scm_wait   = 1'b0;
          s_d.fbe_hold   = 1'b0;
        end else if (ref_loss && (s_q.state == ST_FEE || s_q.state == ST_FBE)) begin
          s_d.state     = ST_SCM;  // see RULE_12
          s_d.req       = REQ_SCM;
          s_d.loss_flag = 1'b1;
        end else if (osc_loss && s_q.state == ST_FEE) begin
          s_d.loss_flag = 1'b1;
          s_d.state     = ext_ref_valid_flag_ok ? ST_FBE : ST_SCM;  // see RULE_19
          s_d.req       = ext_ref_valid_flag_ok ? REQ_FBE : REQ_SCM;
        end else if (s_q.scm_wait) begin
          if (s_q.osc_stable) begin
            s_d.scm_wait = 1'b0;  // see RULE_15
            s_d.state    = target_mode(s_q.req, ext_ref_valid_flag_ok, 1'b1);  // see RULE_16 see RULE_21
          end
        end else if (!stop_req) begin
          s_d.state = target_mode(s_q.req, ext_ref_valid_flag_ok, s_q.osc_stable);  // see RULE_12 see RULE_19 see RULE_21
        end
      end
    endcase

    // any mode change is an expected loss of lock
    if (s_d.state != s_q.state) begin
      s_d.lock     = 1'b0;
      s_d.lock_cnt = 4'h0;
      s_d.acc      = '0;
      s_d.acc_cnt  = 2'h0;
      if (s_d.state == ST_FEE) begin
        s_d.first_lock = 1'b0;  // see RULE_25
      end
    end
    if (s_q.state == ST_OFF) begin
      s_d.lock = 1'b0;
    end
  end

  // a reset only rewrites the clock settings; trim survives everything but power-on
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_q        <= '0;
      s_q.state  <= ST_SCM;  // see RULE_10 see RULE_12
      s_q.filter <= FILTER_RESET;  // see RULE_10
      s_q.req    <= REQ_SCM;
    end else begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge ref_clk or posedge por) begin
    if (por) begin
      trim_q <= TRIM_RESET;
    end else begin
      trim_q <= trim_d;  // see RULE_05
    end
  end

  assign reg_rdata         = s_q.rdata;
  assign filter_value      = s_q.filter;
  assign filter_update     = s_q.filt_upd;
  assign internal_ref_trim = trim_q;  // see RULE_04
  assign actual_mode       = (s_q.state == ST_OFF) ? REQ_SCM : s_q.state[1:0];  // see RULE_23
  assign locked            = s_q.lock;
  assign osc_enable        = (s_q.state != ST_OFF) && (s_q.state != ST_FBE);  // see RULE_20
  assign int_ref_enable    = osc_enable;  // see RULE_20
  assign ext_ref_enable    = ((s_q.state != ST_OFF) || s_q.off_fbe) && s_q.req[1];
  assign crystal_select    = s_q.ref_sel;  // see RULE_20
  assign crystal_range     = s_q.range_sel;
  assign ext_source_select = (s_q.state == ST_FBE);  // see RULE_20
  assign extra_div2        = (s_q.state == ST_FEE) && !s_q.first_lock;  // see RULE_14 see RULE_25
  assign out_divide        = out_divider;  // see RULE_26
  assign loop_multiplier   = multiplier_setting;  // see RULE_26
  assign clock_feed_en     = (s_q.state != ST_OFF) && !s_q.fbe_hold && !(stop_req && !debug_enable);  // see RULE_08

  AST_FILTER_RO: assert property (@(posedge ref_clk) disable iff (rst) // see RULE_01
    (reg_wr && reg_addr == IDX_FILTER_UPPER && s_q.req != REQ_SCM && !(run_mode && sample_valid))
      |=> $stable(filter_value))
    else $error("filter changed by a write outside self-clocked request");

  AST_LATCH_BLOCK: assert property (@(posedge ref_clk) disable iff (rst) // see RULE_03
    (reg_wr && reg_addr == IDX_FILTER_UPPER && s_q.latch_cnt != 3'h0 && !run_mode) |=> !filter_update)
    else $error("upper filter write taken during a latch");

  AST_OFF_ENTRY: assert property (@(posedge ref_clk) disable iff (rst) // see RULE_06
    (stop_req && !debug_enable && !s_q.osc_stop_en && s_q.state != ST_OFF) |=> (s_q.state == ST_OFF))
    else $error("stop without exceptions did not reach off");

  AST_OFF_QUIET: assert property (@(posedge ref_clk) disable iff (rst) // see RULE_06
    (s_q.state == ST_OFF) |-> (!osc_enable && !clock_feed_en && !s_q.osc_stable))
    else $error("clock activity in off state");

  AST_DEBUG_RUN: assert property (@(posedge ref_clk) disable iff (rst) // see RULE_07
    (stop_req && debug_enable && s_q.state != ST_OFF) |=> (s_q.state != ST_OFF) && clock_feed_en)
    else $error("debug enabled but clocks stopped");

  AST_STOP_GATE: assert property (@(posedge ref_clk) disable iff (rst) // see RULE_08
    (stop_req && !debug_enable && s_q.osc_stop_en && s_q.state == ST_FEI) |-> (osc_enable && !clock_feed_en))
    else $error("oscillator-in-stop feed not gated");

  AST_REQ_SCM: assert property (@(posedge ref_clk) disable iff (rst) // see RULE_12
    (run_mode && s_q.req == REQ_SCM && !stop_req && !s_q.scm_wait) |=> (s_q.state == ST_SCM))
    else $error("request 00 did not return to self-clocked");

  AST_FBE_OFF: assert property (@(posedge ref_clk) disable iff (rst) // see RULE_20
    (s_q.state == ST_FBE) |-> (!osc_enable && !int_ref_enable && ext_source_select))
    else $error("bypassed mode left oscillator running");

  AST_DIV2: assert property (@(posedge ref_clk) disable iff (rst) // see RULE_25
    $rose(s_q.state == ST_FEE) |-> extra_div2)
    else $error("divide-by-two missing before first lock");

  AST_WAIT_STABLE: assert property (@(posedge ref_clk) disable iff (rst) // see RULE_15
    (s_q.state == ST_SCM && s_q.scm_wait && !s_q.osc_stable && !stop_req) |=> (s_q.state == ST_SCM))
    else $error("loop closed before oscillator stable");

endmodule

// File: core/fll_clock_pkg.sv
// constants, register map and mode encodings for the frequency loop mode controller
// assumes one 25 MHz ref_clk domain and an 8-bit register port with one-cycle read latency
// How it works
// RULE_01: filter value is writable only while the requested mode is self-clocked (00).
// RULE_02: filter upper nibble sits in upper register 3:0, low byte in lower register.
// RULE_03: upper filter write is ignored while an earlier filter latch is still running.
// RULE_04: trim lengthens the reference period when larger, binary weighted, about 25 percent.
// RULE_05: reset out of stop restores all defaults except the trim setting.
// RULE_06: stop without debug or oscillator-in-stop stops all clocks, enters off; ext_ref_enable stays on in off entered under request 10 with valid reference.
// RULE_07: with debug enabled, clocks keep running as programmed during stop.
// RULE_08: oscillator-in-stop keeps generators running but gates the system clock feed.
// RULE_09: interrupt exit keeps settings; external modes wait for a stable external clock.
// RULE_10: reset exit gives self-clocked mode at the default 8 MHz filter value.
// RULE_11: a crystal must show 4096 clock edges before the external reference is used.
// RULE_12: self-clocked after reset, off exit not 10, X1 to 00, or no reference.
// RULE_13: self-clocked runs open loop, output is oscillator over divider, filter sets frequency.
// RULE_14: entering self-clocked keeps oscillator frequency; extra divide-by-two is dropped.
// RULE_15: off exit with request X1 waits for oscillator stable, then closes the loop.
// RULE_16: internal engaged on request 01 or stable oscillator after off with 01.
// RULE_17: unlocked when error leaves unlock window, stays so while outside lock window.
// RULE_18: lock after enough in-window samples; locked updates use four-sample average.
// RULE_19: bypassed on request 10 with valid reference, off exit, or oscillator loss.
// RULE_20: bypassed mode stops oscillator and internal reference, uses external clock.
// RULE_21: external engaged on request 11 with valid reference and stable oscillator.
// RULE_22: the source must keep the external reference at or below 10 MHz.
// RULE_23: actual mode is reported as 00, 01, 10, 11, lagging the request.
// RULE_24: oscillator stable after two small error changes, not static; cleared in off.
// RULE_25: external engaged adds divide-by-two before first lock, not after.
// RULE_26: output divider and multiplier setting come in as configuration inputs.
package fll_clock_pkg;

  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned FLT_W  = 12;

  localparam logic [ADDR_W-1:0] IDX_FILTER_UPPER = 3'h0;
  localparam logic [ADDR_W-1:0] IDX_FILTER_LOWER = 3'h1;
  localparam logic [ADDR_W-1:0] IDX_TRIM         = 3'h2;
  localparam logic [ADDR_W-1:0] IDX_CONTROL      = 3'h3;
  localparam logic [ADDR_W-1:0] IDX_STATUS       = 3'h4;

  // control register fields
  localparam int unsigned CTL_REQ_LSB   = 0;
  localparam int unsigned CTL_REFSEL    = 2;
  localparam int unsigned CTL_RANGE     = 3;
  localparam int unsigned CTL_OSCSTOP   = 4;
  // status register fields
  localparam int unsigned STS_MODE_LSB  = 0;
  localparam int unsigned STS_LOCK      = 2;
  localparam int unsigned STS_STABLE    = 3;
  localparam int unsigned STS_EXTVALID  = 4;
  localparam int unsigned STS_LOSS      = 5;

  localparam logic [1:0]       REQ_SCM = 2'h0;
  localparam logic [1:0]       REQ_FEI = 2'h1;
  localparam logic [1:0]       REQ_FBE = 2'h2;
  localparam logic [1:0]       REQ_FEE = 2'h3;

  localparam logic [FLT_W-1:0] FILTER_RESET = 12'h200;
  localparam logic [7:0]       TRIM_RESET   = 8'h80;
  localparam logic [2:0]       LATCH_CYCLES = 3'h4;
  localparam logic [3:0]       LOCK_SAMPLES = 4'h4;
  localparam logic [11:0]      LOCK_WIN     = 12'h004;
  localparam logic [11:0]      UNLOCK_WIN   = 12'h010;
  localparam logic [12:0]      XTAL_START_CYCLES = 13'h1000;

  typedef enum logic [2:0] {ST_SCM, ST_FEI, ST_FBE, ST_FEE, ST_OFF} mode_t;

endpackage

// File: dv/ext_ref_source.sv
// model of the external crystal that feeds the clock generator
// assumes ext_ref_enable from the design switches the oscillator amplifier on and off
`timescale 1ns/1ps
module ext_ref_source #(
  parameter int unsigned HALF_NS = 100
) (
  input  wire logic ref_enable,
  output logic      crystal_clk,
  output logic      ref_ok
);
  // 5 MHz stays inside the 2 to 10 MHz band, so the loop can never push the oscillator past its limit
  // the clock stands still while the amplifier is off: a dead crystal does not toggle
  initial begin
    crystal_clk = 1'b0;
    forever begin
      #(HALF_NS);
      crystal_clk = ref_enable ? ~crystal_clk : 1'b0;
    end
  end

  assign ref_ok = ref_enable;
endmodule

// File: dv/fll_clock_mode_controller_test.sv
// self-checking bench for the frequency loop mode controller
// assumes the register map of fll_clock_pkg and the crystal model in ext_ref_source
`timescale 1ns/1ps
module fll_clock_mode_controller_test
  import fll_clock_pkg::*;
;
  logic                    ref_clk;
  logic                    rst;
  logic                    por;
  logic                    reg_wr;
  logic                    reg_rd;
  logic                    stop_req;
  logic                    debug_enable;
  logic                    sample_valid;
  logic                    osc_loss;
  logic                    ref_loss;
  logic [ADDR_W-1:0]       reg_addr;
  logic [DATA_W-1:0]       reg_wdata;
  logic [DATA_W-1:0]       reg_rdata;
  logic signed [FLT_W-1:0] count_error;
  logic                    ext_ref_ok_pin;
  logic                    crystal_input_pin;
  logic [2:0]              out_divider;
  logic [2:0]              multiplier_setting;
  logic [2:0]              out_divide;
  logic [2:0]              loop_multiplier;
  logic [FLT_W-1:0]        filter_value;
  logic [7:0]              internal_ref_trim;
  logic [1:0]              actual_mode;
  logic                    filter_update;
  logic                    locked;
  logic                    osc_enable;
  logic                    int_ref_enable;
  logic                    ext_ref_enable;
  logic                    crystal_select;
  logic                    crystal_range;
  logic                    ext_source_select;
  logic                    extra_div2;
  logic                    clock_feed_en;
  int                      miscompares;
  int                      checks_done;

  fll_clock_mode_controller i_dut (
    .ref_clk(ref_clk), .rst(rst), .por(por), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .stop_req(stop_req),
    .debug_enable(debug_enable), .count_error(count_error), .sample_valid(sample_valid),
    .osc_static(1'b0), .osc_loss(osc_loss), .ref_loss(ref_loss), .ext_ref_ok_pin(ext_ref_ok_pin),
    .crystal_input_pin(crystal_input_pin), .out_divider(out_divider),
    .multiplier_setting(multiplier_setting), .filter_value(filter_value),
    .filter_update(filter_update), .internal_ref_trim(internal_ref_trim),
    .actual_mode(actual_mode), .locked(locked), .osc_enable(osc_enable),
    .int_ref_enable(int_ref_enable), .ext_ref_enable(ext_ref_enable),
    .crystal_select(crystal_select), .crystal_range(crystal_range),
    .ext_source_select(ext_source_select), .extra_div2(extra_div2), .out_divide(out_divide),
    .loop_multiplier(loop_multiplier), .clock_feed_en(clock_feed_en)
  );

  ext_ref_source i_xtal (
    .ref_enable(ext_ref_enable),
    .crystal_clk(crystal_input_pin),
    .ref_ok(ext_ref_ok_pin)
  );

  always #20 ref_clk = ~ref_clk;

  task automatic conclude();
    if (miscompares == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so they are sampled just after that edge
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1;
    chk(16'(reg_rdata), 16'(exp));
  endtask

  task automatic smp(input logic signed [FLT_W-1:0] e, input int k);
    repeat (k) begin
      @(posedge ref_clk);
      count_error  <= e;
      sample_valid <= 1'b1;
      @(posedge ref_clk);
      sample_valid <= 1'b0;
    end
    cyc(1);
  endtask

  task automatic stp(input logic s, input logic d);
    @(posedge ref_clk);
    stop_req     <= s;
    debug_enable <= d;
    cyc(3);
  endtask

  task automatic wait_mode(input logic [1:0] m, input int lim);
    int n;
    n = 0;
    #1;
    while (actual_mode !== m && n < lim) begin
      cyc(1);
      n++;
    end
    chk(16'(actual_mode), 16'(m));
  endtask

  // the crystal start-up alone takes about 20500 cycles
  initial begin
    #2_000_000;
    miscompares++;
    conclude();
  end

  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    por = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    stop_req = 1'b0;
    debug_enable = 1'b0;
    sample_valid = 1'b0;
    osc_loss = 1'b0;
    ref_loss = 1'b0;
    count_error = '0;
    out_divider = 3'h5;
    multiplier_setting = 3'h2;
    miscompares = 0;
    checks_done = 0;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    por <= 1'b0;
    rd(IDX_FILTER_UPPER, 8'h02);
    rd(IDX_FILTER_LOWER, 8'h00);
    rd(IDX_TRIM, 8'h80);
    rd(IDX_STATUS, 8'h00);
    chk(16'(out_divide), 16'h0005);
    chk(16'(loop_multiplier), 16'h0002);
    // second upper write lands two cycles after the first, inside the latch sequence
    wr(IDX_FILTER_LOWER, 8'h34);
    wr(IDX_FILTER_UPPER, 8'h05);
    #1 chk(16'(filter_update), 16'h0001);
    wr(IDX_FILTER_UPPER, 8'h0a);
    #1 chk(16'(filter_update), 16'h0000);
    cyc(1);
    chk(16'(filter_value), 16'h0534);
    rd(IDX_FILTER_UPPER, 8'h05);
    rd(IDX_FILTER_LOWER, 8'h34);
    wr(IDX_TRIM, 8'h3c);
    rd(IDX_TRIM, 8'h3c);
    wr(IDX_CONTROL, 8'h01);
    wait_mode(REQ_FEI, 8);
    chk(16'(osc_enable & int_ref_enable), 16'h0001);
    wr(IDX_FILTER_LOWER, 8'h11);
    wr(IDX_FILTER_UPPER, 8'h07);
    cyc(1);
    chk(16'(filter_value), 16'h0534);
    smp(12'sh000, 5);
    chk(16'(locked), 16'h0001);
    smp(12'sh020, 1);
    chk(16'(locked), 16'h0000);
    stp(1'b1, 1'b1);
    chk(16'(clock_feed_en), 16'h0001);
    chk(16'(actual_mode), 16'h0001);
    stp(1'b0, 1'b0);
    wr(IDX_CONTROL, 8'h11);
    stp(1'b1, 1'b0);
    chk(16'({osc_enable, clock_feed_en}), 16'h0002);
    stp(1'b0, 1'b0);
    wr(IDX_CONTROL, 8'h01);
    stp(1'b1, 1'b0);
    chk(16'({osc_enable, clock_feed_en}), 16'h0000);
    stp(1'b0, 1'b0);
    chk(16'({actual_mode, clock_feed_en}), 16'h0001);
    smp(12'sh000, 3);
    wait_mode(REQ_FEI, 8);
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    rd(IDX_TRIM, 8'h3c);
    rd(IDX_FILTER_UPPER, 8'h02);
    chk(16'(actual_mode), 16'(REQ_SCM));
    wr(IDX_CONTROL, 8'h0e);
    cyc(100);
    chk(16'({actual_mode, crystal_select, crystal_range}), 16'h0003);
    wait_mode(REQ_FBE, 25000);
    chk(16'({ext_source_select, osc_enable, int_ref_enable, ext_ref_enable}), 16'h0009);
    wr(IDX_CONTROL, 8'h07);
    smp(12'sh000, 3);
    wait_mode(REQ_FEE, 8);
    chk(16'(extra_div2), 16'h0001);
    smp(12'sh000, 5);
    chk(16'({locked, extra_div2}), 16'h0002);
    smp(12'sh020, 1);
    chk(16'(extra_div2), 16'h0000);
    wr(IDX_CONTROL, 8'h04);
    wait_mode(REQ_SCM, 8);
    chk(16'(extra_div2), 16'h0000);
    wr(IDX_CONTROL, 8'h07);
    wait_mode(REQ_FEE, 8);
    @(posedge ref_clk);
    osc_loss <= 1'b1;
    @(posedge ref_clk);
    osc_loss <= 1'b0;
    rd(IDX_STATUS, 8'h3a);
    wr(IDX_STATUS, 8'h20);
    rd(IDX_STATUS, 8'h1a);
    @(posedge ref_clk);
    ref_loss <= 1'b1;
    @(posedge ref_clk);
    ref_loss <= 1'b0;
    rd(IDX_CONTROL, 8'h04);
    rd(IDX_STATUS, 8'h28);
    conclude();
  end
endmodule
